/* common/cache_pkg.sv */
// shared constants, types and tag parity for the two-way write-through cache
package cache_pkg;

  // geometry
  localparam int SETS    = 256;
  localparam int IDX_W   = 8;
  localparam int FIELD_W = 12;
  localparam int WORD_W  = 16;
  localparam int ADDR_W  = 22;
  localparam int BLOCK_W = 20;

  // register byte offsets
  localparam logic [7:0] REG_CTRL   = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_HITS   = 8'h08;

  // field positions
  localparam int CTRL_EN_BIT    = 0;
  localparam int CTRL_INIT_BIT  = 1;
  localparam int STAT_BUSY_BIT  = 0;
  localparam int STAT_PERR_BIT  = 1;
  localparam int STAT_RND_BIT   = 2;

  // reset values and last init sweep index
  localparam logic        CTRL_EN_RESET = 1'b1;
  localparam logic [15:0] HITS_RESET    = 16'h0000;
  localparam logic [7:0]  INIT_LAST     = 8'hff;

  typedef enum logic [2:0]
  {
    ST_INIT  = 3'b000,
    ST_IDLE  = 3'b001,
    ST_LOOK  = 3'b010,
    ST_MISS  = 3'b011,
    ST_FILL  = 3'b100,
    ST_WRITE = 3'b101
  } state_t;

  typedef struct packed
  {
    logic [1:0]         par;
    logic               valid;
    logic [FIELD_W-1:0] field;
  } tag_t;

  typedef struct packed
  {
    logic              write;
    logic              byteOp;
    logic              source;
    logic [ADDR_W-1:0] addr;
    logic [WORD_W-1:0] wdata;
  } cache_req_t;

  typedef struct packed
  {
    logic              write;
    logic              byteOp;
    logic [ADDR_W-1:0] addr;
    logic [WORD_W-1:0] wdata;
  } mem_req_t;

  // even parity over two halves; all-zero entry is correct
  function automatic logic [1:0] tagParity(input logic valid, input logic [FIELD_W-1:0] f);
    tagParity = {^{valid, f[11:6]}, ^f[5:0]};
  endfunction : tagParity

endpackage : cache_pkg

/* core/two_way_write_through_cache.sv */
// two-way set associative write-through cache controller with ahb-lite control registers
//
// Local design decisions: the address map and the AHB-Lite interface to the registers.
`timescale 1ns/100ps

// Behaviour
// RQ1: data array 1024 words, 256 sets, two groups
// RQ2: address bits 9:2 pick the set
// RQ3: address bit 1 picks even/odd word
// RQ4: tag is field, valid, two parity bits
// RQ5: two 256-entry tag halves read together
// RQ6: each group compares bits 21:10 separately
// RQ7: hit needs match, valid, good parity
// RQ8: parity check runs beside the compare
// RQ9: read hit returns matching group's word
// RQ10: read miss fetches block by bits 21:2
// RQ11: random bit picks fill group
// RQ12: fill writes block, tag, forwards word together
// RQ13: writes use same lookup as reads
// RQ14: write hit updates only word or byte
// RQ15: every write goes to main memory
// RQ16: write miss leaves arrays unchanged
// RQ17: power-up clears all valid bits first
// RQ18: init writes correct-parity patterns everywhere
// RQ19: requester gives full 22-bit address
// RQ20: address bit 0 selects the byte
// RQ21: parity error acts as miss, flagged
// RQ22: random bit toggles every reference
module two_way_write_through_cache
  import cache_pkg::*;
#(
  parameter int SET_COUNT = SETS
)
(
  // clock, reset, enable
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        ce,
  // requester side
  input  wire logic        reqValid,
  input  wire cache_req_t  req,
  output logic             reqReady,
  output logic             rspValid,
  output logic [15:0]      rspData,
  output logic             rspSource,
  // main memory side
  output logic             memReqValid,
  output mem_req_t         memReq,
  input  wire logic        memReady,
  input  wire logic        memRdValid,
  input  wire logic [31:0] memRdData,
  // ahb-lite register slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata
);

  if (SET_COUNT != SETS)
  begin : g_bad_sets
    $error("set count must equal two to the index width");
  end

  state_t                   state;
  cache_req_t               cur;
  tag_t                     tagMem   [2][SETS];                        // RQ4
  logic [WORD_W-1:0]        dataMem  [2][SETS][2];
  logic [IDX_W-1:0]         initIdx;
  logic                     rnd;
  logic                     fillGroup;
  logic                     cacheEnable;
  logic                     initPending;
  logic                     parityErr;
  logic [15:0]              hitCount;
  logic                     accept;
  logic [IDX_W-1:0]         idx;
  logic                     wordSel;
  logic [FIELD_W-1:0]       field;
  logic [1:0]               hit;
  logic [1:0]               perr;
  logic                     anyHit;
  logic                     hitGroup;
  logic [WORD_W-1:0]        hitWord;
  logic                     busTake;
  logic                     dWrite;
  logic [7:0]               dAddr;
  logic                     regWrite;

  // address split of the held request
  assign idx     = cur.addr[9:2];    // RQ2
  assign wordSel = cur.addr[1];      // RQ3
  assign field   = cur.addr[21:10];

  // per-group compare and parity check side by side
  for (genvar g = 0; g < 2; g++)
  begin : g_group
    tag_t t;
    assign t       = tagMem[g][idx];                                   // RQ5
    assign perr[g] = tagParity(t.valid, t.field) != t.par;             // RQ8
    assign hit[g]  = cacheEnable && t.valid && (t.field == field) && !perr[g]; // RQ6 RQ7 RQ21
  end

  assign anyHit   = |hit;
  assign hitGroup = hit[1];
  assign hitWord  = dataMem[hitGroup][idx][wordSel];                   // RQ9

  assign reqReady = (state == ST_IDLE) && !initPending;
  assign accept   = ce && reqValid && reqReady;

  // main memory request
  assign memReqValid   = (state == ST_MISS) || (state == ST_WRITE);
  assign memReq.write  = (state == ST_WRITE);                          // RQ15
  assign memReq.byteOp = cur.byteOp;                                   // RQ20
  assign memReq.addr   = (state == ST_WRITE) ? cur.addr : {cur.addr[21:2], 2'b00}; // RQ10
  assign memReq.wdata  = cur.wdata;

  // control sequence
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      state <= ST_INIT;                                                // RQ17
    else if (ce)
    begin
      case (state)
        ST_INIT:
          if (initIdx == INIT_LAST)
            state <= ST_IDLE;
        ST_IDLE:
          if (initPending)
            state <= ST_INIT;
          else if (reqValid)
            state <= ST_LOOK;
        ST_LOOK:
          if (cur.write)
            state <= ST_WRITE;                                         // RQ13 RQ15
          else if (anyHit)
            state <= ST_IDLE;
          else
            state <= ST_MISS;                                          // RQ10
        ST_MISS:
          if (memReady)
            state <= ST_FILL;
        ST_FILL:
          if (memRdValid)
            state <= ST_IDLE;
        ST_WRITE:
          if (memReady)
            state <= ST_IDLE;
        default:
          state <= ST_IDLE;
      endcase
    end
  end

  // init sweep index
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      initIdx <= '0;
    else if (ce)
      initIdx <= (state == ST_INIT) ? initIdx + 8'h01 : '0;
  end

  // request capture
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      cur <= '0;
    else if (accept)
      cur <= req;                                                      // RQ19
  end

  // random group bit
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      rnd <= 1'b0;
    else if (accept)
      rnd <= !rnd;                                                     // RQ22
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      fillGroup <= 1'b0;
    else if (ce && state == ST_LOOK)
      fillGroup <= rnd;                                                // RQ11
  end

  // tag store writes
  always_ff @(posedge clk)
  begin
    if (ce)
    begin
      if (state == ST_INIT)
      begin
        tagMem[0][initIdx] <= '0;                                      // RQ17 RQ18
        tagMem[1][initIdx] <= '0;
      end
      else if (state == ST_FILL && memRdValid && cacheEnable)
      begin
        tagMem[fillGroup][idx].field <= field;                         // RQ12
        tagMem[fillGroup][idx].valid <= 1'b1;
        tagMem[fillGroup][idx].par   <= tagParity(1'b1, field);
      end
    end
  end

  // data array writes
  always_ff @(posedge clk)
  begin
    if (ce)
    begin
      if (state == ST_INIT)
      begin
        dataMem[0][initIdx][0] <= '0;                                  // RQ18
        dataMem[0][initIdx][1] <= '0;
        dataMem[1][initIdx][0] <= '0;
        dataMem[1][initIdx][1] <= '0;
      end
      else if (state == ST_FILL && memRdValid && cacheEnable)
      begin
        dataMem[fillGroup][idx][0] <= memRdData[15:0];                 // RQ1 RQ12
        dataMem[fillGroup][idx][1] <= memRdData[31:16];
      end
      else if (state == ST_LOOK && cur.write && anyHit)                // RQ16
      begin
        if (!cur.byteOp)
          dataMem[hitGroup][idx][wordSel] <= cur.wdata;                // RQ14
        else if (cur.addr[0])
          dataMem[hitGroup][idx][wordSel][15:8] <= cur.wdata[15:8];    // RQ20
        else
          dataMem[hitGroup][idx][wordSel][7:0] <= cur.wdata[7:0];      // RQ20
      end
    end
  end

  // answer to the requester
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      rspValid  <= 1'b0;
      rspData   <= '0;
      rspSource <= 1'b0;
    end
    else if (ce)
    begin
      rspValid  <= 1'b0;
      rspSource <= cur.source;
      if (state == ST_LOOK && !cur.write && anyHit)
      begin
        rspValid <= 1'b1;
        rspData  <= hitWord;                                           // RQ9
      end
      else if (state == ST_FILL && memRdValid)
      begin
        rspValid <= 1'b1;
        rspData  <= wordSel ? memRdData[31:16] : memRdData[15:0];      // RQ12
      end
      else if (state == ST_WRITE && memReady)
        rspValid <= 1'b1;
    end
  end

  // bus address phase
  assign busTake   = ce && hsel && hready && htrans[1];
  assign hreadyout = ce;
  assign hresp     = 1'b0;
  assign regWrite  = ce && dWrite;

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      dWrite <= 1'b0;
      dAddr  <= '0;
    end
    else if (ce && hready)
    begin
      dWrite <= busTake && hwrite && (hsize == 3'h2);
      dAddr  <= haddr[7:0];
    end
  end

  // read data
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      hrdata <= '0;
    else if (busTake && !hwrite)
    begin
      if (haddr[7:0] == REG_CTRL)
        hrdata <= {30'h0, 1'b0, cacheEnable};
      else if (haddr[7:0] == REG_STATUS)
        hrdata <= {29'h0, rnd, parityErr, state == ST_INIT};
      else if (haddr[7:0] == REG_HITS)
        hrdata <= {16'h0, hitCount};
      else
        hrdata <= '0;
    end
  end

  // control register
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      cacheEnable <= CTRL_EN_RESET;
    else if (regWrite && dAddr == REG_CTRL)
      cacheEnable <= hwdata[CTRL_EN_BIT];
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      initPending <= 1'b0;
    else if (regWrite && dAddr == REG_CTRL && hwdata[CTRL_INIT_BIT])
      initPending <= 1'b1;
    else if (ce && state == ST_IDLE)
      initPending <= 1'b0;
  end

  // sticky tag parity flag, set wins over clear
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      parityErr <= 1'b0;
    else if (ce && state == ST_LOOK && cacheEnable && |perr)
      parityErr <= 1'b1;                                               // RQ21
    else if (regWrite && dAddr == REG_STATUS && hwdata[STAT_PERR_BIT])
      parityErr <= 1'b0;
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      hitCount <= HITS_RESET;
    else if (ce && state == ST_LOOK && anyHit)
      hitCount <= hitCount + 16'h0001;
    else if (regWrite && dAddr == REG_HITS)
      hitCount <= HITS_RESET;
  end

  // checks
  init_blocks_req_a: // RQ17
    assert property (@(posedge clk) disable iff (!rst_n)
      (state == ST_INIT) |-> !reqReady)
    else $error("request accepted during init");
  init_zero_tag_a: // RQ18
    assert property (@(posedge clk) disable iff (!rst_n)
      (ce && state == ST_INIT) |=> (tagMem[0][$past(initIdx)] == '0)
        && (tagMem[1][$past(initIdx)] == '0))
    else $error("init did not clear tag entry");
  hit_qualified_a: // RQ7
    assert property (@(posedge clk) disable iff (!rst_n)
      (state == ST_LOOK && anyHit) |->
        tagMem[hitGroup][idx].valid && !perr[hitGroup] && tagMem[hitGroup][idx].field == field)
    else $error("hit without valid matching tag");
  read_hit_data_a: // RQ9
    assert property (@(posedge clk) disable iff (!rst_n)
      (ce && state == ST_LOOK && !cur.write && anyHit) |=> rspValid && rspData == $past(hitWord))
    else $error("read hit returned wrong word");
  miss_block_a: // RQ10
    assert property (@(posedge clk) disable iff (!rst_n)
      (memReqValid && !memReq.write) |-> memReq.addr[21:2] == cur.addr[21:2])
    else $error("miss fetch has wrong block address");
  fill_tag_a: // RQ12
    assert property (@(posedge clk) disable iff (!rst_n)
      (ce && state == ST_FILL && memRdValid && cacheEnable) |=>
        tagMem[fillGroup][idx].valid && tagMem[fillGroup][idx].field == field && rspValid)
    else $error("fill did not load tag and answer");
  write_through_a: // RQ15
    assert property (@(posedge clk) disable iff (!rst_n)
      (ce && state == ST_LOOK && cur.write) |=> memReqValid && memReq.write
        && memReq.addr == cur.addr)
    else $error("write not sent to main memory");
  write_miss_keep_a: // RQ16
    assert property (@(posedge clk) disable iff (!rst_n)
      (ce && state == ST_LOOK && cur.write && !anyHit) |=>
        $stable(tagMem[0][idx]) && $stable(tagMem[1][idx]) && $stable(dataMem[0][idx][wordSel])
        && $stable(dataMem[1][idx][wordSel]))
    else $error("write miss altered cache");
  write_hit_word_a: // RQ14
    assert property (@(posedge clk) disable iff (!rst_n)
      (ce && state == ST_LOOK && cur.write && anyHit && !cur.byteOp) |=>
        dataMem[$past(hitGroup)][$past(idx)][$past(wordSel)] == $past(cur.wdata))
    else $error("write hit did not update word");
  parity_flag_a: // RQ21
    assert property (@(posedge clk) disable iff (!rst_n)
      (ce && state == ST_LOOK && cacheEnable && |perr) |=> parityErr)
    else $error("tag parity error not flagged");
  random_toggle_a: // RQ22
    assert property (@(posedge clk) disable iff (!rst_n)
      accept |=> rnd != $past(rnd))
    else $error("random bit did not toggle");

endmodule : two_way_write_through_cache

/* dv/main_mem_model.sv */
// main memory model answering block fetches and write-through stores
`timescale 1ns/100ps
module main_mem_model
  import cache_pkg::*;
(
  // clock and reset
  input  wire logic     clk,
  input  wire logic     rst_n,
  // cache side
  input  wire logic     memReqValid,
  input  wire mem_req_t memReq,
  output logic          memReady,
  output logic          memRdValid,
  output logic [31:0]   memRdData
);
  logic [15:0] store [int];
  logic [15:0] cur;
  logic [20:0] fillWord;
  logic        fillPend;
  int          waitN;

  function automatic logic [15:0] peek(input logic [20:0] w);
    peek = store.exists(w) ? store[w] : 16'(w * 7);
  endfunction : peek

  // stalls at random; fill data line toggles when not valid
  always @(posedge clk)
  begin
    memReady <= rst_n && ($urandom_range(2, 0) == 0);
    memRdValid <= 1'b0;
    memRdData <= ~memRdData;
    if (!rst_n)
    begin
      fillPend <= 1'b0;
      memRdData <= 32'h0;
      waitN <= 0;
    end
    else if (memReqValid && memReady && memReq.write)
    begin
      cur = peek(memReq.addr[21:1]);
      if (!memReq.byteOp)
        cur = memReq.wdata;
      else if (memReq.addr[0])
        cur[15:8] = memReq.wdata[15:8];
      else
        cur[7:0] = memReq.wdata[7:0];
      store[memReq.addr[21:1]] = cur;
    end
    else if (memReqValid && memReady)
    begin
      fillPend <= 1'b1;
      fillWord <= memReq.addr[21:1];
      waitN <= $urandom_range(3, 0);
    end
    else if (fillPend && waitN == 0)
    begin
      memRdValid <= 1'b1;
      memRdData <= {peek(fillWord | 21'h1), peek(fillWord)};
      fillPend <= 1'b0;
    end
    else if (fillPend)
      waitN <= waitN - 1;
  end
endmodule : main_mem_model

/* dv/tb_top.sv */
// self-checking testbench for the two-way write-through cache
`timescale 1ns/100ps
module tb_top
  import cache_pkg::*;
;
  logic        clk, rst_n, ce, reqValid, reqReady, rspValid, rspSource;
  logic        memReqValid, memReady, memRdValid, hsel, hwrite, hreadyout, hresp, miss;
  cache_req_t  req;
  mem_req_t    memReq;
  logic [15:0] rspData, got;
  logic [31:0] memRdData, haddr, hwdata, hrdata, rd;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [21:0] a0, a;
  logic [15:0] refMem [int];
  int          err_total, num_checks;

  two_way_write_through_cache i_two_way_write_through_cache (.clk(clk), .rst_n(rst_n),
    .ce(ce), .reqValid(reqValid), .req(req), .reqReady(reqReady), .rspValid(rspValid),
    .rspData(rspData), .rspSource(rspSource), .memReqValid(memReqValid), .memReq(memReq),
    .memReady(memReady), .memRdValid(memRdValid), .memRdData(memRdData), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata));

  main_mem_model i_main_mem_model (.clk(clk), .rst_n(rst_n), .memReqValid(memReqValid),
    .memReq(memReq), .memReady(memReady), .memRdValid(memRdValid), .memRdData(memRdData));

  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      err_total++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : report_and_stop

  function automatic logic [15:0] refWord(input logic [21:0] x);
    refWord = refMem.exists(x[21:1]) ? refMem[x[21:1]] : 16'(x[21:1] * 7);
  endfunction : refWord

  task automatic ahb(input logic wr, input logic [7:0] ad, input logic [31:0] wd,
                     output logic [31:0] rdv);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= {24'h0, ad};
    hwrite <= wr;
    do @(posedge clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    do @(posedge clk); while (hreadyout !== 1'b1);
    rdv = hrdata;
    check(hresp, 1'b0);
  endtask : ahb

  task automatic xfer(input logic wr, input logic bo, input logic [21:0] x,
                      input logic [15:0] wd);
    int n;
    miss = 1'b0;
    req <= '{write: wr, byteOp: bo, source: x[3], addr: x, wdata: wd};
    reqValid <= 1'b1;
    do @(posedge clk); while (reqReady !== 1'b1);
    reqValid <= 1'b0;
    n = 0;
    while (rspValid !== 1'b1 && n < 300)
    begin
      if (memReqValid === 1'b1)
      begin
        miss = 1'b1;
        check({memReq.write, memReq.addr}, {wr, wr ? x : {x[21:2], 2'b00}});
      end
      @(posedge clk);
      n++;
    end
    check(rspValid, 1'b1);
    check(rspSource, x[3]);
    if (!wr && !miss)
      check(n, 2);
    if (wr)
      check(miss, 1'b1);
    got = rspData;
  endtask : xfer

  task automatic rd_chk(input logic [21:0] x, input int em);
    xfer(1'b0, 1'b0, x, 16'h0);
    check(got, refWord(x));
    if (em < 2)
      check(miss, em[0]);
  endtask : rd_chk

  task automatic wr_do(input logic [21:0] x, input logic bo, input logic [15:0] d);
    logic [15:0] w;
    xfer(1'b1, bo, x, d);
    w = refWord(x);
    if (!bo)
      w = d;
    else if (x[0])
      w[15:8] = d[15:8];
    else
      w[7:0] = d[7:0];
    refMem[x[21:1]] = w;
  endtask : wr_do

  initial
  begin
    #60000;
    err_total++;
    report_and_stop();
  end

  initial
  begin
    int n;
    void'($urandom(32'h6a6d5109));
    err_total = 0;
    num_checks = 0;
    rst_n = 1'b0;
    ce = 1'b1;
    reqValid = 1'b0;
    req = '0;
    hsel = 1'b0;
    htrans = 2'b00;
    haddr = 32'h0;
    hwrite = 1'b0;
    hsize = 3'b010;
    hwdata = 32'h0;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    ahb(1'b0, REG_STATUS, 32'h0, rd);
    check(rd[STAT_BUSY_BIT], 1'b1);
    ahb(1'b0, REG_CTRL, 32'h0, rd);
    check(rd, 32'h1);
    ahb(1'b0, REG_HITS, 32'h0, rd);
    check(rd, 32'h0);
    ahb(1'b1, 8'h10, 32'hffffffff, rd);
    ahb(1'b0, 8'h10, 32'h0, rd);
    check(rd, 32'h0);
    repeat (230) @(posedge clk);
    check(reqReady, 1'b0);
    n = 0;
    while (reqReady !== 1'b1 && n < 60)
    begin
      @(posedge clk);
      n++;
    end
    check(reqReady, 1'b1);
    $display("test init done");
    a0 = 22'h012a08;
    rd_chk(a0, 1);
    rd_chk(a0 ^ 22'h2, 0);
    rd_chk(a0 ^ 22'h4, 1);
    rd_chk(a0 ^ 22'h400, 1);
    ahb(1'b1, REG_HITS, 32'h0, rd);
    rd_chk(a0, 0);
    rd_chk(a0 ^ 22'h400, 0);
    ahb(1'b0, REG_HITS, 32'h0, rd);
    check(rd, 32'h2);
    wr_do(a0 | 22'h1, 1'b1, 16'hab00);
    rd_chk(a0, 0);
    wr_do(a0 ^ 22'h800, 1'b0, 16'h1234);
    rd_chk(a0, 0);
    rd_chk(a0 ^ 22'h400, 0);
    rd_chk(a0 ^ 22'h800, 1);
    ahb(1'b1, REG_CTRL, 32'h0, rd);
    rd_chk(a0 ^ 22'h4, 1);
    ahb(1'b1, REG_CTRL, 32'h1, rd);
    rd_chk(a0 ^ 22'h4, 0);
    hsize <= 3'b000;
    ahb(1'b1, REG_CTRL, 32'h0, rd);
    hsize <= 3'b010;
    ahb(1'b0, REG_CTRL, 32'h0, rd);
    check(rd, 32'h1);
    ce <= 1'b0;
    repeat (3) @(posedge clk);
    check(hreadyout, 1'b0);
    ce <= 1'b1;
    @(posedge clk);
    rd_chk(a0 ^ 22'h4, 0);
    ahb(1'b1, REG_CTRL, 32'h3, rd);
    @(posedge clk);
    check(reqReady, 1'b0);
    ahb(1'b0, REG_STATUS, 32'h0, rd);
    check(rd[STAT_BUSY_BIT], 1'b1);
    n = 0;
    while (reqReady !== 1'b1 && n < 300)
    begin
      @(posedge clk);
      n++;
    end
    check(reqReady, 1'b1);
    rd_chk(a0 ^ 22'h4, 1);
    rd_chk(a0, 1);
    $display("test directed done");
    for (int i = 0; i < 120; i++)
    begin
      a = 22'($urandom) & 22'h000c1f;
      if ($urandom_range(2, 0) == 0)
        wr_do(a & {21'h1fffff, a[0] & a[4]}, a[4], 16'($urandom));
      else
        rd_chk(a, 2);
    end
    ahb(1'b1, REG_STATUS, 32'h2, rd);
    ahb(1'b0, REG_STATUS, 32'h0, rd);
    check(rd[STAT_PERR_BIT], 1'b0);
    $display("test random done");
    report_and_stop();
  end
endmodule : tb_top
